// ### rtl/swi_cfg.svh
/*
 * Stopwatch interrupt/control block: addresses, bit positions,
 * reset values and timing figures.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SWI_CFG_SVH
`define SWI_CFG_SVH

// ==========================================================
// register addresses
`define SWI_ADDR_GATES   16'hff16
`define SWI_ADDR_DIRECT  16'hff48
`define SWI_ADDR_KMASK   16'hff49
`define SWI_ADDR_CTRL    16'hff4a
`define SWI_ADDR_D_MS    16'hff4b
`define SWI_ADDR_D_CS    16'hff4c
`define SWI_ADDR_D_DS    16'hff4d
`define SWI_ADDR_IFLAG   16'hff4e
`define SWI_ADDR_IMASK   16'hff4f

// ==========================================================
// bit positions
`define SWI_GATE_SW      1
`define SWI_DIR_EN       0
`define SWI_DIR_SWAP     1
`define SWI_CTRL_CLR     0
`define SWI_CTRL_RUN     1
`define SWI_CTRL_RNW     2
`define SWI_CTRL_LCU     3
`define SWI_IRQ_TENTH    0
`define SWI_IRQ_ONE      1
`define SWI_IRQ_RUN      2
`define SWI_IRQ_LAP      3

// ==========================================================
// reset values and digit maximum
`define SWI_RST_NIB      4'h0
`define SWI_RST_KMASK    3'h0
`define SWI_DIGIT_MAX    4'h9

// ==========================================================
// timing
`define SWI_MCLK_HZ      200000000
`define SWI_MCLK_NS      5
`define SWI_SAMPLE_HZ    1024
`define SWI_MS_US        1000

`endif

// ### rtl/swi_pkg.sv
/*
 * Types shared by the stopwatch interrupt/control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package swi_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [3:0]  wdata;
        logic        wr;
        logic        rd;
    } swi_bus_t;

    // capture buffer hold state
    typedef enum logic [1:0] {
        SWI_FREE    = 2'b00,
        SWI_HELD    = 2'b01,
        SWI_RENEWED = 2'b11
    } swi_hold_t;

endpackage : swi_pkg

// ### rtl/swi_bcd_digit.sv
/*
 * One BCD counter digit with wrap output.
 * Assumes inc is a one-cycle pulse on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swi_cfg.svh"

module swi_bcd_digit (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       inc,
    output logic [3:0]      value,
    output logic            wrap
);

    // a clear swallows a wrap in the same cycle
    assign wrap = inc && !clear && (value == `SWI_DIGIT_MAX);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            value <= `SWI_RST_NIB;
        end else if (clear) begin
            value <= `SWI_RST_NIB;
        end else if (inc) begin
            value <= wrap ? `SWI_RST_NIB : value + 4'h1;
        end
    end

endmodule : swi_bcd_digit
`default_nettype wire

// ### rtl/swi_stopwatch.sv
/*
 * Stopwatch control, direct key input, capture buffer, interrupt
 * flags and register port.
 * Assumes keys are raw pins, register port on mclk.
 */
// Notes on behaviour
// - hundredths overflow raises 10 Hz irq, tenths overflow raises 1 Hz irq
// - overflow is digit 9 to 0; matching factor flag set then
// - 10 Hz and 1 Hz each masked separately; flags set regardless
// - with direct input on, keys sampled at 1024 Hz tick; rising edge sets flag
// - run and lap irqs masked separately; flags set regardless
// - stopwatch clock gate bit enables counting; readable, resets 0
// - direct enable hands run/stop and lap to keys; readable, resets 0
// - direct enable change applies at next 1024 Hz tick
// - key swap bit: 0 pin a run, pin b lap; 1 swapped
// - read-only lap carry request bit, resets 0
// - writing 1 to clear bit resets counter; reads 0
// - unused bits and clear bit read 0; writes ignored
// - 3-bit key mask selects blocking keys; resets 0
// - run bit writable only with direct off; reads running state
// - renewed flag updated on tenths read; hold kept when renewed
// - hundredths and tenths registers read capture, thousandths reads live count while free; thousandths read triggers hold
`timescale 1ns/100ps
`default_nettype none
`include "swi_cfg.svh"

module swi_stopwatch #(
    parameter int unsigned SAMPLE_CYCLES = `SWI_MCLK_HZ / `SWI_SAMPLE_HZ,
    parameter int unsigned MS_CYCLES     = `SWI_MS_US * 1000 / `SWI_MCLK_NS
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire swi_pkg::swi_bus_t bus,
    output logic [3:0]            bus_rdata,
    input  wire logic             key_pin_a,
    input  wire logic             key_pin_b,
    input  wire logic [5:0]       mask_keys,
    output logic [3:0]            unit_clock_gates,
    output logic [3:0]            irq_request,
    output logic                  stopwatch_running,
    output logic [11:0]           counter_digits
);

    // ==========================================================
    // register state
    logic [1:0]          direct_input_control;
    logic [2:0]          key_mask_select;
    logic [3:0]          irq_flags;
    logic [3:0]          irq_masks;
    logic                sw_run_pend;
    logic                key_control_enable_act;
    logic                running;
    logic [11:0]         capture;
    swi_pkg::swi_hold_t  hold_st;
    logic                lap_carry_request;
    logic                capture_renewed_flag;

    // ==========================================================
    // address decode
    wire wr_gates = bus.wr && bus.addr == `SWI_ADDR_GATES;
    wire wr_dir   = bus.wr && bus.addr == `SWI_ADDR_DIRECT;
    wire wr_kmask = bus.wr && bus.addr == `SWI_ADDR_KMASK;
    wire wr_ctrl  = bus.wr && bus.addr == `SWI_ADDR_CTRL;
    wire wr_iflag = bus.wr && bus.addr == `SWI_ADDR_IFLAG;
    wire wr_imask = bus.wr && bus.addr == `SWI_ADDR_IMASK;
    wire rd_ms    = bus.rd && bus.addr == `SWI_ADDR_D_MS;
    wire rd_ds    = bus.rd && bus.addr == `SWI_ADDR_D_DS;
    wire counter_clear = wr_ctrl && bus.wdata[`SWI_CTRL_CLR];
    wire key_control_enable = direct_input_control[`SWI_DIR_EN];
    wire key_role_swap      = direct_input_control[`SWI_DIR_SWAP];
    wire stopwatch_clock_gate = unit_clock_gates[`SWI_GATE_SW];

    // ==========================================================
    // 1024 Hz sampling tick, free running
    logic [17:0] smp_cnt;
    wire sample_tick = smp_cnt == 18'(SAMPLE_CYCLES - 1);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) smp_cnt <= '0;
        else smp_cnt <= sample_tick ? '0 : smp_cnt + 18'h1;
    end

    // ==========================================================
    // key pins: three flops, accept once stages two and three agree
    logic [7:0] ks1, ks2, ks3, kf;
    wire  [7:0] kraw = {mask_keys, key_pin_b, key_pin_a};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ks1 <= '0;
            ks2 <= '0;
            ks3 <= '0;
            kf  <= '0;
        end else begin
            ks1 <= kraw;
            ks2 <= ks1;
            ks3 <= ks2;
            kf  <= (ks2 & ks3) | (kf & (ks2 | ks3));
        end
    end

    // ==========================================================
    // direct key decode and key mask
    localparam logic [5:0] KM_TABLE [8] = '{6'h00, 6'h01, 6'h03, 6'h07,
                                            6'h04, 6'h0c, 6'h1c, 6'h3c};
    logic blocked;
    logic run_int;
    logic lap_int;
    wire run_key  = key_role_swap ? kf[1] : kf[0];
    wire lap_key  = key_role_swap ? kf[0] : kf[1];
    wire mask_hit = |(kf[7:2] & KM_TABLE[key_mask_select]);
    wire next_run_int = key_control_enable_act && run_key && !blocked && !mask_hit;
    wire next_lap_int = key_control_enable_act && lap_key && !blocked && !mask_hit;
    wire run_edge = sample_tick && next_run_int && !run_int;
    wire lap_edge = sample_tick && next_lap_int && !lap_int;

    // blocking lasts until both keys are released with no mask key down
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            blocked  <= 1'b0;
            run_int  <= 1'b0;
            lap_int  <= 1'b0;
            key_control_enable_act <= 1'b0;
        end else if (sample_tick) begin
            blocked  <= mask_hit || (blocked && (run_key || lap_key));
            run_int  <= next_run_int;
            lap_int  <= next_lap_int;
            key_control_enable_act <= key_control_enable;
        end
    end

    // ==========================================================
    // run/stop, applied on the sampling tick
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sw_run_pend <= 1'b0;
            running     <= 1'b0;
        end else begin
            if (wr_ctrl && !key_control_enable_act) sw_run_pend <= bus.wdata[`SWI_CTRL_RUN];
            if (sample_tick) begin
                if (key_control_enable_act) begin
                    running     <= running ^ run_edge;
                    sw_run_pend <= running ^ run_edge;
                end else begin
                    running <= sw_run_pend;
                end
            end
        end
    end

    // ==========================================================
    // counter chain, 1 ms step
    logic [17:0] ms_cnt;
    logic [2:0]  dwrap;
    wire count_en = running && stopwatch_clock_gate;
    wire ms_tick  = count_en && ms_cnt == 18'(MS_CYCLES - 1);
    wire [2:0] dinc = {dwrap[1:0], ms_tick};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) ms_cnt <= '0;
        else if (counter_clear || ms_tick) ms_cnt <= '0;
        else if (count_en) ms_cnt <= ms_cnt + 18'h1;
    end

    for (genvar i = 0; i < 3; i++) begin : g_digit
        swi_bcd_digit u_digit (
            .mclk    (mclk),
            .reset_n (reset_n),
            .clear   (counter_clear),
            .inc     (dinc[i]),
            .value   (counter_digits[4*i +: 4]),
            .wrap    (dwrap[i])
        );
    end

    // ==========================================================
    // interrupt flags: set beats a same-cycle clear
    wire [3:0] irq_set = {lap_edge, run_edge, dwrap[2], dwrap[1]};
    wire [3:0] irq_clr = wr_iflag ? bus.wdata : 4'h0;
    wire [3:0] next_irq_flags = (irq_flags & ~irq_clr) | irq_set;
    wire [3:0] next_irq_masks = wr_imask ? bus.wdata : irq_masks;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flags   <= `SWI_RST_NIB;
            irq_masks   <= `SWI_RST_NIB;
            irq_request <= `SWI_RST_NIB;
        end else begin
            irq_flags   <= next_irq_flags;
            irq_masks   <= next_irq_masks;
            irq_request <= next_irq_flags & next_irq_masks;
        end
    end

    // ==========================================================
    // capture buffer; a lap in the same cycle as a read wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            capture              <= '0;
            hold_st              <= swi_pkg::SWI_FREE;
            lap_carry_request    <= 1'b0;
            capture_renewed_flag <= 1'b0;
        end else if (lap_edge) begin
            capture           <= counter_digits;
            lap_carry_request <= irq_flags[`SWI_IRQ_ONE];
            hold_st <= (hold_st == swi_pkg::SWI_FREE) ? swi_pkg::SWI_HELD
                                                      : swi_pkg::SWI_RENEWED;
        end else if (rd_ms && hold_st == swi_pkg::SWI_FREE) begin
            capture           <= counter_digits;
            lap_carry_request <= irq_flags[`SWI_IRQ_ONE];
            hold_st           <= swi_pkg::SWI_HELD;
        end else if (rd_ds) begin
            capture_renewed_flag <= hold_st == swi_pkg::SWI_RENEWED;
            hold_st <= (hold_st == swi_pkg::SWI_RENEWED) ? swi_pkg::SWI_HELD
                                                         : swi_pkg::SWI_FREE;
        end
    end

    // ==========================================================
    // plain registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unit_clock_gates     <= `SWI_RST_NIB;
            direct_input_control <= 2'h0;
            key_mask_select      <= `SWI_RST_KMASK;
        end else begin
            if (wr_gates) unit_clock_gates <= bus.wdata;
            if (wr_dir) direct_input_control <= bus.wdata[1:0];
            if (wr_kmask) key_mask_select <= bus.wdata[2:0];
        end
    end

    // ==========================================================
    // read mux; unused bits and clear bit read zero
    wire [3:0] ctrl_rd = {lap_carry_request, capture_renewed_flag, running, 1'b0};
    wire [3:0] ms_rd = (hold_st == swi_pkg::SWI_FREE) ? counter_digits[3:0]
                                                      : capture[3:0];
    wire [3:0] rd_value =
        (bus.addr == `SWI_ADDR_GATES)  ? unit_clock_gates :
        (bus.addr == `SWI_ADDR_DIRECT) ? {2'h0, direct_input_control} :
        (bus.addr == `SWI_ADDR_KMASK)  ? {1'b0, key_mask_select} :
        (bus.addr == `SWI_ADDR_CTRL)   ? ctrl_rd :
        (bus.addr == `SWI_ADDR_D_MS)   ? ms_rd :
        (bus.addr == `SWI_ADDR_D_CS)   ? capture[7:4] :
        (bus.addr == `SWI_ADDR_D_DS)   ? capture[11:8] :
        (bus.addr == `SWI_ADDR_IFLAG)  ? irq_flags :
        (bus.addr == `SWI_ADDR_IMASK)  ? irq_masks : 4'h0;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) bus_rdata <= 4'h0;
        else bus_rdata <= bus.rd ? rd_value : 4'h0;
    end

    assign stopwatch_running = running;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_tenth_flag;
        dinc[1] && counter_digits[7:4] == 4'h9 && !counter_clear |=> irq_flags[0];
    endproperty
    a_tenth_flag: assert property (p_tenth_flag) else $error("10 Hz flag missed");

    property p_one_flag;
        dwrap[2] |=> irq_flags[1] && counter_digits[11:8] == 4'h0;
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("1 Hz flag missed");

    property p_masked_set;
        dwrap[1] && !next_irq_masks[0] |=> irq_flags[0] && !irq_request[0];
    endproperty
    a_masked_set: assert property (p_masked_set) else $error("masked flag wrong");

    property p_req_and;
        irq_request == (irq_flags & irq_masks);
    endproperty
    a_req_and: assert property (p_req_and) else $error("request not flag and mask");

    property p_no_key_flag;
        !key_control_enable_act && !irq_flags[2] && !irq_flags[3] |=> !irq_flags[2] && !irq_flags[3];
    endproperty
    a_no_key_flag: assert property (p_no_key_flag) else $error("key flag while off");

    property p_dir_on_tick;
        $changed(key_control_enable_act) |-> $past(sample_tick);
    endproperty
    a_dir_on_tick: assert property (p_dir_on_tick) else $error("direct change off tick");

    property p_run_on_tick;
        $changed(running) |-> $past(sample_tick);
    endproperty
    a_run_on_tick: assert property (p_run_on_tick) else $error("run change off tick");

    property p_clear;
        counter_clear |=> counter_digits == 12'h000 ##1 ms_cnt <= 18'h1;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    property p_ctrl_bit0;
        bus.rd && bus.addr == `SWI_ADDR_CTRL |=> !bus_rdata[0];
    endproperty
    a_ctrl_bit0: assert property (p_ctrl_bit0) else $error("clear bit read 1");

    property p_renew;
        rd_ds && !lap_edge && hold_st == swi_pkg::SWI_RENEWED
            |=> capture_renewed_flag && hold_st == swi_pkg::SWI_HELD;
    endproperty
    a_renew: assert property (p_renew) else $error("renewal handling wrong");

    property p_lap_flag;
        lap_edge |=> irq_flags[3] && hold_st != swi_pkg::SWI_FREE;
    endproperty
    a_lap_flag: assert property (p_lap_flag) else $error("lap not taken");

    c_run_edge: cover property (run_edge);
    c_lap_edge: cover property (lap_edge);
    c_renewed: cover property (rd_ds && hold_st == swi_pkg::SWI_RENEWED);
    c_one_sec: cover property (dwrap[2]);

endmodule : swi_stopwatch
`default_nettype wire

// ### tb/swi_key_model.sv
/*
 * Push keys on the general input port pins of the stopwatch.
 * Assumes the bench sets button levels; pins read high while pressed.
 */
`timescale 1ns/100ps
`default_nettype none

module swi_key_model (
    input  wire logic       mclk,
    input  wire logic [1:0] btn,
    input  wire logic [5:0] mask_btn,
    output logic            key_pin_a,
    output logic            key_pin_b,
    output logic [5:0]      mask_keys
);
    // ==========================================================
    // key contacts
    // clean contacts: no bounce, so the device's stage two/three agreement filter is never exercised
    // keys feed only this block; port irq selects for both pins stay cleared
    always @(posedge mclk) begin
        key_pin_a <= btn[0];
        key_pin_b <= btn[1];
        mask_keys <= mask_btn;
    end
endmodule : swi_key_model

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench of the stopwatch control block.
 * Assumes the key model on the port pins and short count parameters.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic              mclk;
    logic              reset_n;
    swi_pkg::swi_bus_t bus;
    logic [3:0]        bus_rdata;
    logic [3:0]        rd_val;
    logic [1:0]        btn;
    logic [5:0]        mask_btn;
    logic              key_pin_a;
    logic              key_pin_b;
    logic [5:0]        mask_keys;
    logic [3:0]        unit_clock_gates;
    logic [3:0]        irq_request;
    logic              stopwatch_running;
    logic [11:0]       counter_digits;
    int                mismatches;
    int                total_checks;

    swi_stopwatch #(.SAMPLE_CYCLES(8), .MS_CYCLES(4)) i_swi_stopwatch (
        .mclk(mclk), .reset_n(reset_n), .bus(bus), .bus_rdata(bus_rdata),
        .key_pin_a(key_pin_a), .key_pin_b(key_pin_b), .mask_keys(mask_keys),
        .unit_clock_gates(unit_clock_gates), .irq_request(irq_request),
        .stopwatch_running(stopwatch_running), .counter_digits(counter_digits)
    );

    swi_key_model i_swi_key_model (
        .mclk(mclk), .btn(btn), .mask_btn(mask_btn),
        .key_pin_a(key_pin_a), .key_pin_b(key_pin_b), .mask_keys(mask_keys)
    );

    always #2.5 mclk = ~mclk;

    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask : rd

    task automatic press(input int k);
        btn[k] <= 1'b1;
        repeat (40) @(posedge mclk);
        btn[k] <= 1'b0;
        repeat (40) @(posedge mclk);
    endtask : press

    task automatic wait_tenths(input logic [3:0] v);
        for (int n = 0; n < 5000 && counter_digits[11:8] !== v; n++) @(posedge mclk);
        #1 chk("tenths", counter_digits[11:8], v);
    endtask : wait_tenths

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [3:0] m, input logic [3:0] e);
        rd(a);
        chk(what, rd_val & m, e);
    endtask : rd_chk

    // ==========================================================
    // scenarios
    task automatic t_reset_values;
        logic [15:0] a [10] = '{16'hff16, 16'hff48, 16'hff49, 16'hff4a, 16'hff4b,
                                16'hff4c, 16'hff4d, 16'hff4e, 16'hff4f, 16'hff50};
        for (int i = 0; i < 10; i++) rd_chk("reset reg", a[i], 4'hf, 4'h0);
        chk("outputs", {irq_request, stopwatch_running, counter_digits}, 17'h00000);
    endtask : t_reset_values

    task automatic t_access;
        logic [15:0] a [6] = '{16'hff16, 16'hff48, 16'hff49, 16'hff4a, 16'hff4b, 16'hff50};
        logic [3:0]  e [6] = '{4'hf, 4'h3, 4'h7, 4'h0, 4'h0, 4'h0};
        for (int i = 0; i < 6; i++) begin
            wr(a[i], a[i] == 16'hff4a ? 4'hd : 4'hf);
            rd_chk("access", a[i], 4'hf, e[i]);
        end
        chk("gates out", unit_clock_gates, 4'hf);
        wr(16'hff48, 4'h0);
        wr(16'hff49, 4'h0);
        wr(16'hff16, 4'h2);
        // let the direct-off setting reach a tick before software run writes
        repeat (12) @(posedge mclk);
    endtask : t_access

    task automatic t_overflow;
        wr(16'hff4f, 4'h1);
        wr(16'hff4a, 4'h2);
        repeat (12) @(posedge mclk);
        chk("running", stopwatch_running, 1'b1);
        wait_tenths(4'h1);
        rd_chk("flags 10hz", 16'hff4e, 4'hf, 4'h1);
        chk("irq 10hz", irq_request, 4'h1);
        wait_tenths(4'h9);
        wait_tenths(4'h0);
        rd_chk("flags 1hz", 16'hff4e, 4'hf, 4'h3);
        chk("irq masked", irq_request, 4'h1);
        wr(16'hff4a, 4'h0);
        repeat (12) @(posedge mclk);
        chk("stopped", stopwatch_running, 1'b0);
        wr(16'hff4e, 4'hf);
        rd_chk("flags clr", 16'hff4e, 4'hf, 4'h0);
        wr(16'hff4a, 4'h1);
        repeat (3) @(posedge mclk);
        chk("cleared", counter_digits, 12'h000);
    endtask : t_overflow

    task automatic t_keys;
        wr(16'hff4f, 4'hc);
        press(0);
        rd_chk("no direct", 16'hff4e, 4'hf, 4'h0);
        wr(16'hff48, 4'h1);
        repeat (12) @(posedge mclk);
        press(0);
        rd_chk("run flag", 16'hff4e, 4'hf, 4'h4);
        chk("irq run", {irq_request, stopwatch_running}, 5'h09);
        wr(16'hff4a, 4'h0);
        repeat (12) @(posedge mclk);
        chk("sw run ignored", stopwatch_running, 1'b1);
        press(1);
        rd_chk("lap flag", 16'hff4e, 4'hf, 4'hc);
        wr(16'hff4e, 4'hf);
        wr(16'hff48, 4'h3);
        repeat (12) @(posedge mclk);
        press(0);
        rd_chk("swapped", 16'hff4e, 4'hf, 4'h8);
        chk("still run", stopwatch_running, 1'b1);
        wr(16'hff4e, 4'hf);
        wr(16'hff49, 4'h1);
        mask_btn <= 6'h01;
        press(1);
        mask_btn <= 6'h00;
        rd_chk("masked key", 16'hff4e, 4'hf, 4'h0);
        chk("mask run", stopwatch_running, 1'b1);
        wr(16'hff49, 4'h0);
    endtask : t_keys

    task automatic t_capture;
        rd(16'hff4b);
        press(0);
        rd(16'hff4c);
        rd(16'hff4d);
        rd_chk("renewed", 16'hff4a, 4'h7, 4'h6);
        rd(16'hff4b);
        rd(16'hff4c);
        rd(16'hff4d);
        rd_chk("renew clr", 16'hff4a, 4'h7, 4'h2);
        // swapped keys: pin b toggles run, so this stops the count
        press(1);
        chk("key stop", stopwatch_running, 1'b0);
        rd(16'hff4b);
        chk("digit ms", rd_val, counter_digits[3:0]);
        rd(16'hff4c);
        chk("digit cs", rd_val, counter_digits[7:4]);
        rd(16'hff4d);
        chk("digit ds", rd_val, counter_digits[11:8]);
        wr(16'hff16, 4'h0);
    endtask : t_capture

    // ==========================================================
    // verdict and sequence
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end

    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        bus = '0;
        btn = 2'b00;
        mask_btn = 6'h00;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset_values();
        t_access();
        t_overflow();
        t_keys();
        t_capture();
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
